//--- hw/gfc_pkg.sv
// package: constants shared by the gated frequency counter files
package gfc_pkg;

	// ============================================================
	// register map (wishbone byte addresses)
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RESULT = 4'h8;

	// ============================================================
	// field positions
	localparam int CTRL_RUN_BIT      = 0;
	localparam int CTRL_LONG_BIT     = 1;
	localparam int STAT_NEW_BIT      = 0;
	localparam int STAT_GATE_BIT     = 1;
	localparam int STAT_LONG_BIT     = 2;
	localparam int STAT_PRESET_LSB   = 4;

	// ============================================================
	// reset values
	localparam logic [1:0] CTRL_RESET   = 2'h0;
	localparam logic [1:0] PRESET_RESET = 2'h0;

	// ============================================================
	// prescaler states and presets
	localparam logic [1:0] PRESC_TOP     = 2'h3;
	localparam logic [1:0] PRESC_ZERO    = 2'h0;
	localparam logic [1:0] PRESET_AFT_30 = 2'h3;
	localparam logic [1:0] PRESET_AFT_03 = 2'h1;

	// ============================================================
	// gate timing: counted in reference periods by bcd divider digits
	localparam int         REF_KHZ        = 10;
	localparam int         GATE_SHORT_MS  = 40;
	localparam int         GATE_LONG_MS   = 400;
	localparam int         SHORT_TICKS    = GATE_SHORT_MS * REF_KHZ;
	localparam int         LONG_TICKS     = GATE_LONG_MS * REF_KHZ;
	localparam logic [3:0] SHORT_END_DIG  = 4'(SHORT_TICKS / 100);
	localparam logic [3:0] LONG_END_DIG   = 4'(LONG_TICKS / 1000);

	// ============================================================
	// top decade presets, digit wrap
	localparam logic [3:0] TOP_PRESET_SHORT = 4'h2;
	localparam logic [3:0] TOP_PRESET_LONG  = 4'h0;
	localparam logic [3:0] BCD_MAX          = 4'h9;

	// measurement phases
	typedef enum logic [1:0] {PH_GATE, PH_STORE, PH_SET, PH_RESTART} gfc_phase_t;

endpackage

//--- hw/gfc_decade.sv
// file: one bcd decade with enable, carry, preset, latch and 7-segment decoder
`timescale 1ns/1ps
`default_nettype none

module gfc_decade (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	// counting
	input  wire logic       inc_i,
	input  wire logic       load_i,
	input  wire logic [3:0] load_val_i,
	input  wire logic       store_i,
	output logic            carry_o,
	output logic      [3:0] cnt_o,
	// display
	output logic      [3:0] latch_o,
	output logic      [6:0] seg_o
);

	logic [3:0] cnt_r, cnt_nxt, latch_r, latch_nxt;
	logic [6:0] seg_r, seg_nxt;

	// ============================================================
	// count, load and latch next values
	always_comb begin
		cnt_nxt   = cnt_r;
		latch_nxt = latch_r;
		carry_o   = inc_i && (cnt_r == gfc_pkg::BCD_MAX);
		if (load_i) begin
			cnt_nxt = load_val_i;
		end else if (inc_i) begin
			cnt_nxt = (cnt_r == gfc_pkg::BCD_MAX) ? 4'h0 : cnt_r + 4'h1;
		end
		if (store_i) begin
			latch_nxt = cnt_r;
		end
		// segments gfedcba, driven from the new latch value
		case (latch_nxt)
			4'h0: seg_nxt = 7'h3f;
			4'h1: seg_nxt = 7'h06;
			4'h2: seg_nxt = 7'h5b;
			4'h3: seg_nxt = 7'h4f;
			4'h4: seg_nxt = 7'h66;
			4'h5: seg_nxt = 7'h6d;
			4'h6: seg_nxt = 7'h7d;
			4'h7: seg_nxt = 7'h07;
			4'h8: seg_nxt = 7'h7f;
			4'h9: seg_nxt = 7'h6f;
			default: seg_nxt = 7'h00;
		endcase
	end

	// registers
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			cnt_r   <= 4'h0;
			latch_r <= 4'h0;
			seg_r   <= 7'h3f;
		end else begin
			cnt_r   <= cnt_nxt;
			latch_r <= latch_nxt;
			seg_r   <= seg_nxt;
		end
	end

	assign cnt_o   = cnt_r;
	assign latch_o = latch_r;
	assign seg_o   = seg_r;

endmodule // gfc_decade

`default_nettype wire

//--- hw/gfc_div10.sv
// file: one divide-by-ten stage of the gate timing chain
`timescale 1ns/1ps
`default_nettype none

module gfc_div10 (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	// control
	input  wire logic       clr_i,
	input  wire logic       en_i,
	// state
	output logic      [3:0] q_o,
	output logic            carry_o
);

	logic [3:0] q_r, q_nxt;

	// next state; carry is a one-cycle enable for the next stage
	always_comb begin
		q_nxt   = q_r;
		carry_o = en_i && (q_r == gfc_pkg::BCD_MAX);
		if (clr_i) begin
			q_nxt = 4'h0;
		end else if (en_i) begin
			q_nxt = (q_r == gfc_pkg::BCD_MAX) ? 4'h0 : q_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			q_r <= 4'h0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;

endmodule // gfc_div10

`default_nettype wire

//--- hw/gfc_top.sv
// file: gated frequency counter top with prescaler, gate control and wishbone slave
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gfc_top #(
	parameter int NUM_DEC = 5
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  resetn_i,
	// pins
	input  wire logic                  carrier_i,
	input  wire logic                  ref_10k_i,
	// control signals out
	output logic                       gate_o,
	output logic                       store_o,
	output logic                       set_o,
	// display
	output logic [4*NUM_DEC-1:0]       bcd_o,
	output logic [7*NUM_DEC-1:0]       seg_o,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o
);

	// ============================================================
	// pin synchronisers and edge detection
	logic [2:0] car_s_r, ref_s_r;
	logic       car_edge, ref_tick;

	// stage 1 feeds only stage 2; stage 3 is for edge finding
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			car_s_r <= 3'h0;
			ref_s_r <= 3'h0;
		end else begin
			car_s_r <= {car_s_r[1], car_s_r[0], carrier_i};
			ref_s_r <= {ref_s_r[1], ref_s_r[0], ref_10k_i};
		end
	end
	assign car_edge = car_s_r[1] && !car_s_r[2];
	assign ref_tick = ref_s_r[1] && !ref_s_r[2];

	// ============================================================
	// gate timing chain
	logic [3:0] ch_q [4];
	logic [4:0] ch_en;
	logic       ch_clr;
	gfc_pkg::gfc_phase_t phase_r, phase_nxt;

	// chain only runs while the gate is open, so digits freeze at close
	assign ch_en[0] = ref_tick && (phase_r == gfc_pkg::PH_GATE);
	assign ch_clr   = ref_tick && (phase_r == gfc_pkg::PH_RESTART);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chain
			gfc_div10 u_div (
				.core_clk_i (core_clk_i),
				.resetn_i   (resetn_i),
				.clr_i      (ch_clr),
				.en_i       (ch_en[gi]),
				.q_o        (ch_q[gi]),
				.carry_o    (ch_en[gi+1])
			);
		end
	endgenerate

	// ============================================================
	// measurement sequencer and gate flop
	logic       gate_r, gate_nxt, long_r, long_nxt;
	logic       run_r, run_nxt, lreq_r, lreq_nxt;
	logic       gate_end, store_pls, set_pls;

	// short path is blocked in long mode; long closes at count four thousand
	assign gate_end = long_r ? (ch_q[3] == gfc_pkg::LONG_END_DIG)
	                         : (ch_q[2] == gfc_pkg::SHORT_END_DIG);
	assign store_pls = ref_tick && (phase_r == gfc_pkg::PH_STORE);
	assign set_pls   = ref_tick && (phase_r == gfc_pkg::PH_SET);

	always_comb begin
		phase_nxt = phase_r;
		gate_nxt  = gate_r;
		long_nxt  = long_r;
		case (phase_r)
			gfc_pkg::PH_GATE: begin
				if (gate_end) begin
					gate_nxt  = 1'b0;
					phase_nxt = gfc_pkg::PH_STORE;
				end
			end
			gfc_pkg::PH_STORE: begin
				if (ref_tick) phase_nxt = gfc_pkg::PH_SET;
			end
			gfc_pkg::PH_SET: begin
				if (ref_tick) begin
					long_nxt  = lreq_r;
					phase_nxt = gfc_pkg::PH_RESTART;
				end
			end
			gfc_pkg::PH_RESTART: begin
				// stopped by software: wait here with the gate shut
				if (ref_tick && run_r) begin
					gate_nxt  = 1'b1;
					phase_nxt = gfc_pkg::PH_GATE;
				end
			end
			default: phase_nxt = gfc_pkg::PH_RESTART;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			phase_r <= gfc_pkg::PH_RESTART;
			gate_r  <= 1'b0;
			long_r  <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			gate_r  <= gate_nxt;
			long_r  <= long_nxt;
		end
	end

	// ============================================================
	// 4:1 prescaler and last-digit compensation
	logic [1:0] presc_r, presc_nxt, psel_r, psel_nxt;
	logic       mem3_r, mem3_nxt, mem0_r, mem0_nxt;
	logic       clr3_r, clr3_nxt, clr0_r, clr0_nxt;
	logic       presc_adv, presc_out, pls_30, pls_03;

	assign presc_adv = car_edge && gate_r;
	assign presc_out = presc_adv && (presc_r == gfc_pkg::PRESC_TOP);
	// direction pulses: new memory set while the other still holds
	assign pls_30 = store_pls && (presc_r == gfc_pkg::PRESC_ZERO) && mem3_r;
	assign pls_03 = store_pls && (presc_r == gfc_pkg::PRESC_TOP) && mem0_r;

	always_comb begin
		presc_nxt = presc_r;
		psel_nxt  = psel_r;
		mem3_nxt  = mem3_r;
		mem0_nxt  = mem0_r;
		clr3_nxt  = 1'b0;
		clr0_nxt  = 1'b0;
		if (set_pls) begin
			presc_nxt = psel_r;
		end else if (presc_adv) begin
			presc_nxt = presc_r + 2'h1;
		end
		// delayed clear of the opposite memory, one cycle late
		if (clr3_r) mem3_nxt = 1'b0;
		if (clr0_r) mem0_nxt = 1'b0;
		if (store_pls && presc_r == gfc_pkg::PRESC_TOP) begin
			mem3_nxt = 1'b1;
			clr0_nxt = 1'b1;
		end
		if (store_pls && presc_r == gfc_pkg::PRESC_ZERO) begin
			mem0_nxt = 1'b1;
			clr3_nxt = 1'b1;
		end
		if (pls_30) psel_nxt = gfc_pkg::PRESET_AFT_30;
		if (pls_03) psel_nxt = gfc_pkg::PRESET_AFT_03;
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			presc_r <= 2'h0;
			psel_r  <= gfc_pkg::PRESET_RESET;
			mem3_r  <= 1'b0;
			mem0_r  <= 1'b0;
			clr3_r  <= 1'b0;
			clr0_r  <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			psel_r  <= psel_nxt;
			mem3_r  <= mem3_nxt;
			mem0_r  <= mem0_nxt;
			clr3_r  <= clr3_nxt;
			clr0_r  <= clr0_nxt;
		end
	end

	// ============================================================
	// result decades
	logic [NUM_DEC:0]     dec_inc;
	logic [4*NUM_DEC-1:0] dec_cnt;
	logic [3:0]           top_pre;

	assign dec_inc[0] = presc_out;
	// preset follows the selection being taken at this set pulse
	assign top_pre = lreq_r ? gfc_pkg::TOP_PRESET_LONG : gfc_pkg::TOP_PRESET_SHORT;

	generate
		for (gi = 0; gi < NUM_DEC; gi++) begin : g_dec
			// one counter, latch and decoder per digit
			gfc_decade u_dec (
				.core_clk_i (core_clk_i),
				.resetn_i   (resetn_i),
				.inc_i      (dec_inc[gi]),
				.load_i     (set_pls),
				.load_val_i ((gi == NUM_DEC-1) ? top_pre : 4'h0),
				.store_i    (store_pls),
				.carry_o    (dec_inc[gi+1]),
				.cnt_o      (dec_cnt[4*gi +: 4]),
				.latch_o    (bcd_o[4*gi +: 4]),
				.seg_o      (seg_o[7*gi +: 7])
			);
		end
	endgenerate

	// ============================================================
	// wishbone slave: one registered ack, the cycle after the strobe, registered read data
	logic        ack_r, ack_nxt, new_r, new_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        wb_req, wb_wr;

	assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

	always_comb begin
		ack_nxt  = wb_req;
		rd_nxt   = 32'h0;
		run_nxt  = run_r;
		lreq_nxt = lreq_r;
		new_nxt  = new_r;
		if (wb_wr && wb_adr_i == gfc_pkg::ADDR_CTRL) begin
			run_nxt  = wb_dat_i[gfc_pkg::CTRL_RUN_BIT];
			lreq_nxt = wb_dat_i[gfc_pkg::CTRL_LONG_BIT];
		end
		// write one clears; a store in the same cycle wins
		if (wb_wr && wb_adr_i == gfc_pkg::ADDR_STATUS && wb_dat_i[gfc_pkg::STAT_NEW_BIT]) new_nxt = 1'b0;
		if (store_pls) new_nxt = 1'b1;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				gfc_pkg::ADDR_CTRL: begin
					rd_nxt[gfc_pkg::CTRL_RUN_BIT]  = run_r;
					rd_nxt[gfc_pkg::CTRL_LONG_BIT] = lreq_r;
				end
				gfc_pkg::ADDR_STATUS: begin
					rd_nxt[gfc_pkg::STAT_NEW_BIT]                          = new_r;
					rd_nxt[gfc_pkg::STAT_GATE_BIT]                         = gate_r;
					rd_nxt[gfc_pkg::STAT_LONG_BIT]                         = long_r;
					rd_nxt[gfc_pkg::STAT_PRESET_LSB +: 2]                  = psel_r;
				end
				gfc_pkg::ADDR_RESULT: rd_nxt[4*NUM_DEC-1:0] = bcd_o;
				default: rd_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ack_r  <= 1'b0;
			rd_r   <= 32'h0;
			run_r  <= gfc_pkg::CTRL_RESET[gfc_pkg::CTRL_RUN_BIT];
			lreq_r <= gfc_pkg::CTRL_RESET[gfc_pkg::CTRL_LONG_BIT];
			new_r  <= 1'b0;
		end else begin
			ack_r  <= ack_nxt;
			rd_r   <= rd_nxt;
			run_r  <= run_nxt;
			lreq_r <= lreq_nxt;
			new_r  <= new_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rd_r;
	assign gate_o   = gate_r;
	assign store_o  = store_pls;
	assign set_o    = set_pls;

	// ============================================================
	// assertions
	property p_closed_gate_frozen;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(!gate_r && !set_pls) |=> $stable(presc_r);
	endproperty
	a_closed_gate_frozen: assert property (p_closed_gate_frozen) else $error("prescaler moved with gate shut");

	property p_presc_out;
		@(posedge core_clk_i) disable iff (!resetn_i)
		presc_out |=> (presc_r == 2'h0) && (dec_cnt[3:0] != $past(dec_cnt[3:0]));
	endproperty
	a_presc_out: assert property (p_presc_out) else $error("prescaler wrap did not advance units");

	property p_mem_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(store_pls && presc_r == 2'h3) |=> mem3_r ##1 !mem0_r;
	endproperty
	a_mem_set: assert property (p_mem_set) else $error("state three not memorised");

	property p_mem_clear;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(store_pls && presc_r == 2'h0 && mem3_r) |=> (mem0_r && mem3_r && psel_r == 2'h3) ##1 !mem3_r;
	endproperty
	a_mem_clear: assert property (p_mem_clear) else $error("delayed memory clear wrong");

	property p_preset;
		@(posedge core_clk_i) disable iff (!resetn_i)
		set_pls |=> presc_r == $past(psel_r);
	endproperty
	a_preset: assert property (p_preset) else $error("prescaler not preset");

	property p_long_close;
		@(posedge core_clk_i) disable iff (!resetn_i)
		($fell(gate_r) && long_r) |-> (ch_q[3] == 4'h4) && (ch_q[2] == 4'h0);
	endproperty
	a_long_close: assert property (p_long_close) else $error("long gate closed at wrong count");

	property p_short_close;
		@(posedge core_clk_i) disable iff (!resetn_i)
		($fell(gate_r) && !long_r) |-> (ch_q[2] == 4'h4) && (ch_q[3] == 4'h0);
	endproperty
	a_short_close: assert property (p_short_close) else $error("short gate closed at wrong count");

	property p_sel_only_at_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!set_pls |=> $stable(long_r);
	endproperty
	a_sel_only_at_set: assert property (p_sel_only_at_set) else $error("gate time changed mid cycle");

	property p_top_preset;
		@(posedge core_clk_i) disable iff (!resetn_i)
		set_pls |=> dec_cnt[4*NUM_DEC-1 -: 4] == (long_r ? 4'h0 : 4'h2) && dec_cnt[3:0] == 4'h0;
	endproperty
	a_top_preset: assert property (p_top_preset) else $error("decade preset wrong");

	property p_store_latch;
		@(posedge core_clk_i) disable iff (!resetn_i)
		store_pls |=> (bcd_o == $past(dec_cnt)) && !gate_r;
	endproperty
	a_store_latch: assert property (p_store_latch) else $error("latch missed counts");

endmodule // gfc_top

`default_nettype wire

//--- dv/gfc_src.sv
// partner model: tuning oscillator carrier pulses and scaled 10 kHz reference
`timescale 1ns/1ps
`default_nettype none

module gfc_src (
	// clock
	input  wire logic       core_clk_i,
	// carrier control
	input  wire logic       car_run_i,
	input  wire logic [7:0] car_half_i,
	// pins
	output logic            carrier_o,
	output logic            ref_10k_o
);
	// ============================================================
	// sources
	logic [7:0] car_cnt_r = 8'h00;
	logic [2:0] ref_cnt_r = 3'h0;

	// reference runs free, scaled to 8 core clocks so a long gate fits the run
	always_ff @(posedge core_clk_i) begin
		ref_cnt_r <= ref_cnt_r + 3'h1;
	end
	assign ref_10k_o = ref_cnt_r[2];

	// carrier parks low while stopped, like a gated oscillator output
	always_ff @(posedge core_clk_i) begin
		if (!car_run_i) begin
			car_cnt_r <= 8'h00;
			carrier_o <= 1'b0;
		end else if (car_cnt_r + 8'h01 >= car_half_i) begin
			car_cnt_r <= 8'h00;
			carrier_o <= ~carrier_o;
		end else begin
			car_cnt_r <= car_cnt_r + 8'h01;
		end
	end
endmodule // gfc_src
`default_nettype wire

//--- dv/gfc_top_tb.sv
// testbench: gated frequency counter fed by the carrier and reference model
`timescale 1ns/1ps
`default_nettype none

module gfc_top_tb;
	// ============================================================
	// signals
	logic        core_clk_i, resetn_i, car_run, carrier, ref_10k;
	logic        gate_o, store_o, set_o, wb_ack_o;
	logic        wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  car_half;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [19:0] bcd_o, got;
	logic [34:0] seg_o;
	logic [2:0]  ctl;
	int          errors, total_checks, n, i, d, t0, len, nom;
	int          cyc_cnt = 0;

	// ============================================================
	// case table: carrier half period, long gate, expected display
	logic [7:0]  row_half [4] = '{8'h04, 8'h05, 8'h08, 8'h04};
	logic        row_long [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic [19:0] row_bcd  [4] = '{20'h20100, 20'h20080, 20'h20050, 20'h01000};
	logic [6:0]  segs [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};

	assign ctl = {set_o, store_o, gate_o};

	// ============================================================
	// instances
	gfc_src src (.core_clk_i(core_clk_i), .car_run_i(car_run), .car_half_i(car_half),
		.carrier_o(carrier), .ref_10k_o(ref_10k));
	gfc_top dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .carrier_i(carrier), .ref_10k_i(ref_10k),
		.gate_o(gate_o), .store_o(store_o), .set_o(set_o), .bcd_o(bcd_o), .seg_o(seg_o),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	// clock and free cycle count for gate lengths
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) cyc_cnt <= cyc_cnt + 1;

	// ============================================================
	// helpers
	task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] seen);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// classic single cycle; the slave's ack edge is where data is taken
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int t;
		@(posedge core_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		t = 0;
		do begin
			@(posedge core_clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (t >= 20) begin
			errors++;
			$display("MISMATCH wb_ack expected 1 seen timeout");
			test_done();
		end
	endtask

	// wait for gate (0), store (1) or set (2) to reach a level
	task automatic wait_lvl(input int which, input logic lvl, input int lim);
		int t;
		t = 0;
		do begin
			@(posedge core_clk_i);
			t++;
		end while (ctl[which] !== lvl && t < lim);
		if (ctl[which] !== lvl) begin
			errors++;
			$display("MISMATCH wait %0d expected %b seen timeout", which, lvl);
			test_done();
		end
	endtask

	function automatic int bcd2int(input logic [15:0] b);
		return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
	endfunction

	// ============================================================
	// main sequence
	initial begin
		resetn_i = 1'b0;
		car_run  = 1'b0;
		car_half = 8'h04;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		errors = 0;
		total_checks = 0;
		repeat (20) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		// reset state, unmapped place, write with low lane disabled
		chk("bcd_rst", 35'h0, {15'h0, bcd_o});
		chk("seg_rst", {5{7'h3f}}, seg_o);
		chk("gate_rst", 35'h0, {34'h0, gate_o});
		chk("ctl_rst", 35'h0, {32'h0, ctl});
		wb(1'b0, 4'hc, 32'h0, 4'hf);
		chk("unmapped", 35'h0, {3'h0, rd});
		wb(1'b1, gfc_pkg::ADDR_CTRL, 32'h3, 4'h0);
		wb(1'b0, gfc_pkg::ADDR_CTRL, 32'h0, 4'hf);
		chk("ctrl", {33'h0, gfc_pkg::CTRL_RESET}, {3'h0, rd});
		car_run <= 1'b1;
		// table: mode adopted at a set, then one full measurement checked
		for (i = 0; i < 4; i++) begin
			car_half <= row_half[i];
			wb(1'b1, gfc_pkg::ADDR_CTRL, {30'h0, row_long[i], 1'b1}, 4'hf);
			wait_lvl(2, 1'b1, 40000);
			wait_lvl(0, 1'b1, 100);
			t0 = cyc_cnt;
			if (row_long[i]) wb(1'b1, gfc_pkg::ADDR_CTRL, 32'h1, 4'hf);
			wait_lvl(0, 1'b0, 40000);
			len = cyc_cnt - t0;
			nom = row_long[i] ? 32000 : 3200;
			chk("gate_len", (len >= nom - 2 && len <= nom + 2) ? len : nom, len);
			wait_lvl(1, 1'b1, 40);
			n = 0;
			do begin
				@(posedge core_clk_i);
				n++;
				if (n == 1) got = bcd_o;
			end while (set_o !== 1'b1 && n < 40);
			chk("store_to_set", 35'h8, n);
			d = bcd2int(got[15:0]) - bcd2int(row_bcd[i][15:0]);
			chk("units", (d >= -1 && d <= 1) ? got[15:0] : row_bcd[i][15:0], got[15:0]);
			chk("top", row_bcd[i][19:16], got[19:16]);
			@(posedge core_clk_i);
			chk("seg_top", segs[row_bcd[i][19:16]], seg_o[34:28]);
			wb(1'b0, gfc_pkg::ADDR_RESULT, 32'h0, 4'hf);
			chk("result", got, rd[19:0]);
			wb(1'b0, gfc_pkg::ADDR_STATUS, 32'h0, 4'hf);
			chk("preset", (rd[5:4] == 2'h2) ? 2'h0 : rd[5:4], rd[5:4]);
		end
		// stopping: current measurement completes, no new gate opens
		wb(1'b1, gfc_pkg::ADDR_CTRL, 32'h0, 4'hf);
		wait_lvl(2, 1'b1, 40000);
		n = 0;
		repeat (200) begin
			@(posedge core_clk_i);
			if (gate_o !== 1'b0) n++;
		end
		chk("gate_idle", 35'h0, n);
		test_done();
	end
endmodule // gfc_top_tb
`default_nettype wire
